// [logic/mbrw_slave.sv]
/*
  Slave frame handler: read/write-multiple queries and exception answers.
  Assumes a byte receiver that flags the end of each frame, a byte
  transmitter with ready, and a register map answering combinationally.
*/
`timescale 1ns/10ps
`include "mbrw_consts.svh"
module mbrw_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] slave_addr_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_end_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [15:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_we_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_exists_i,
  input wire logic reg_read_only_i,
  input wire logic reg_in_range_i,
  input wire logic reg_run_locked_i,
  input wire logic run_state_i,
  input wire logic trip_state_i,
  input wire logic undervoltage_state_i,
  input wire logic soft_lock_i,
  output logic other_func_o,
  output logic busy_o
);

  mbrw_pkg::mbrw_main_t q;
  mbrw_pkg::mbrw_main_t d;
  logic [7:0] rx_buf [0:`MBRW_BUF_DEPTH-1];
  logic buf_we;
  logic [7:0] fr_addr;
  logic [7:0] fr_fc;
  logic [15:0] rd_start;
  logic [15:0] rd_qty;
  logic [15:0] wr_start;
  logic [15:0] wr_qty;
  logic [7:0] wr_bytes;
  logic [8:0] exp_len;
  logic fc_known;
  logic fmt_ok;
  logic state_block;
  logic last_wr;
  logic last_rd;
  logic [7:0] nxt_pos;
  logic tx_take;

  mbrw_crc_if rx_crc ();
  mbrw_crc_if tx_crc ();

  mbrw_crc u_rx_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .crc_if(rx_crc.engine)
  );

  mbrw_crc u_tx_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .crc_if(tx_crc.engine)
  );

  //////////////////////////////////////////////////////////////////////////
  // Query fields held in the receive buffer

  assign fr_addr = rx_buf[`MBRW_POS_ADDR];
  assign fr_fc = rx_buf[`MBRW_POS_FC];
  assign rd_start = {rx_buf[`MBRW_POS_RA], rx_buf[`MBRW_POS_RA + 8'h01]};
  assign rd_qty = {rx_buf[`MBRW_POS_RQ], rx_buf[`MBRW_POS_RQ + 8'h01]};
  assign wr_start = {rx_buf[`MBRW_POS_WA], rx_buf[`MBRW_POS_WA + 8'h01]};
  assign wr_qty = {rx_buf[`MBRW_POS_WQ], rx_buf[`MBRW_POS_WQ + 8'h01]};
  assign wr_bytes = rx_buf[`MBRW_POS_BC];

  assign exp_len = `MBRW_HDR_LEN + `MBRW_CRC_LEN + {1'b0, wr_bytes};

  assign fc_known = (fr_fc == `MBRW_FC_RD_COILS) ||
                    (fr_fc == `MBRW_FC_RD_REGS) ||
                    (fr_fc == `MBRW_FC_WR_COIL) ||
                    (fr_fc == `MBRW_FC_WR_REG) ||
                    (fr_fc == `MBRW_FC_WR_COILS) ||
                    (fr_fc == `MBRW_FC_WR_REGS) ||
                    (fr_fc == `MBRW_FC_RW_REGS);

  // Counts, lengths and byte count must agree
  assign fmt_ok = !q.ovf &&
                  ({1'b0, q.cnt} == exp_len) &&
                  ({8'h00, wr_bytes} == 16'(wr_qty << 1)) &&
                  (rd_qty != 16'h0000) &&
                  (rd_qty <= `MBRW_MAX_RD_QTY) &&
                  (wr_qty != 16'h0000) &&
                  (wr_qty <= `MBRW_MAX_WR_QTY);

  // Device states that refuse any write; running refuses only run-locked registers
  assign state_block = trip_state_i || undervoltage_state_i ||
                       soft_lock_i ||
                       (run_state_i && reg_run_locked_i);

  assign last_wr = (16'({8'h00, q.idx} + 16'h0001) == wr_qty);
  assign last_rd = (16'({8'h00, q.idx} + 16'h0001) == rd_qty);
  assign nxt_pos = 8'(`MBRW_POS_WDATA + {q.idx[6:0], 1'b0} + 8'h02);
  assign tx_take = q.tx_valid && tx_ready_i;

  //////////////////////////////////////////////////////////////////////////
  // CRC engine hookup

  assign buf_we = (q.st == mbrw_pkg::mbrw_s_idle) && rx_valid_i &&
                  !rx_end_i && !q.ovf;

  assign rx_crc.clear = (q.st != mbrw_pkg::mbrw_s_idle) || rx_end_i;
  assign rx_crc.valid = buf_we;
  assign rx_crc.data = rx_data_i;

  assign tx_crc.clear = (q.st != mbrw_pkg::mbrw_s_tx);
  assign tx_crc.valid = tx_take && (q.tx != mbrw_pkg::mbrw_t_crcl) &&
                        (q.tx != mbrw_pkg::mbrw_t_crch);
  assign tx_crc.data = q.tx_data;

  always_ff @(posedge clk_i) begin
    if (buf_we) begin
      rx_buf[q.cnt] <= rx_data_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame sequencing

  always_comb begin
    d = q;
    d.other = 1'b0;
    unique case (q.st)
      mbrw_pkg::mbrw_s_idle: begin
        if (rx_end_i) begin
          d.cnt = 8'h00;
          d.ovf = 1'b0;
          d.exc = 1'b0;
          d.idx = 8'h00;
          d.tx = mbrw_pkg::mbrw_t_addr;
          if (q.cnt < `MBRW_MIN_FRAME && !q.ovf) begin
            d.st = mbrw_pkg::mbrw_s_idle;
          end else if (rx_crc.crc != 16'h0000) begin
            d.st = mbrw_pkg::mbrw_s_idle;
          end else if (fr_addr == `MBRW_BROADCAST) begin
            d.st = mbrw_pkg::mbrw_s_idle;
          end else if (fr_addr != slave_addr_i) begin
            d.st = mbrw_pkg::mbrw_s_idle;
          end else if (!fc_known) begin
            d.st = mbrw_pkg::mbrw_s_tx;
            d.exc = 1'b1;
            d.exc_code = `MBRW_EXC_FUNC;
          end else if (fr_fc != `MBRW_FC_RW_REGS) begin
            d.other = 1'b1;
          end else if (!fmt_ok) begin
            d.st = mbrw_pkg::mbrw_s_tx;
            d.exc = 1'b1;
            d.exc_code = `MBRW_EXC_FORMAT;
          end else begin
            d.st = mbrw_pkg::mbrw_s_chkw;
            d.addr = 16'(wr_start + `MBRW_REG_BASE);
            d.wdata = {rx_buf[`MBRW_POS_WDATA],
                       rx_buf[`MBRW_POS_WDATA + 8'h01]};
          end
        end else if (rx_valid_i) begin
          if (q.cnt == 8'hff) begin
            d.ovf = 1'b1;
          end else if (!q.ovf) begin
            d.cnt = q.cnt + 8'h01;
          end
        end
      end
      mbrw_pkg::mbrw_s_chkw: begin
        if (!reg_exists_i) begin
          d.st = mbrw_pkg::mbrw_s_tx;
          d.exc = 1'b1;
          d.exc_code = `MBRW_EXC_ADDR;
        end else if (reg_read_only_i) begin
          d.st = mbrw_pkg::mbrw_s_tx;
          d.exc = 1'b1;
          d.exc_code = `MBRW_EXC_RDONLY;
        end else if (state_block) begin
          d.st = mbrw_pkg::mbrw_s_tx;
          d.exc = 1'b1;
          d.exc_code = `MBRW_EXC_STATE;
        end else if (!reg_in_range_i) begin
          d.st = mbrw_pkg::mbrw_s_tx;
          d.exc = 1'b1;
          d.exc_code = `MBRW_EXC_RANGE;
        end else if (last_wr) begin
          d.st = mbrw_pkg::mbrw_s_chkr;
          d.idx = 8'h00;
          d.addr = 16'(rd_start + `MBRW_REG_BASE);
        end else begin
          d.idx = q.idx + 8'h01;
          d.addr = q.addr + 16'h0001;
          d.wdata = {rx_buf[nxt_pos], rx_buf[8'(nxt_pos + 8'h01)]};
        end
      end
      mbrw_pkg::mbrw_s_chkr: begin
        if (!reg_exists_i) begin
          d.st = mbrw_pkg::mbrw_s_tx;
          d.exc = 1'b1;
          d.exc_code = `MBRW_EXC_ADDR;
        end else if (last_rd) begin
          d.st = mbrw_pkg::mbrw_s_write;
          d.idx = 8'h00;
          d.addr = 16'(wr_start + `MBRW_REG_BASE);
          d.wdata = {rx_buf[`MBRW_POS_WDATA],
                     rx_buf[`MBRW_POS_WDATA + 8'h01]};
        end else begin
          d.idx = q.idx + 8'h01;
          d.addr = q.addr + 16'h0001;
        end
      end
      mbrw_pkg::mbrw_s_write: begin
        // Writes complete before any read-back
        if (last_wr) begin
          d.st = mbrw_pkg::mbrw_s_tx;
          d.idx = 8'h00;
          d.addr = 16'(rd_start + `MBRW_REG_BASE);
        end else begin
          d.idx = q.idx + 8'h01;
          d.addr = q.addr + 16'h0001;
          d.wdata = {rx_buf[nxt_pos], rx_buf[8'(nxt_pos + 8'h01)]};
        end
      end
      mbrw_pkg::mbrw_s_tx: begin
        if (!q.tx_valid) begin
          d.tx_valid = 1'b1;
          unique case (q.tx)
            mbrw_pkg::mbrw_t_addr: begin
              d.tx_data = slave_addr_i;
            end
            mbrw_pkg::mbrw_t_fc: begin
              d.tx_data = q.exc ? 8'(fr_fc + `MBRW_EXC_OFFSET)
                                : fr_fc;
            end
            mbrw_pkg::mbrw_t_cnt: begin
              d.tx_data = q.exc ? q.exc_code
                                : 8'(rd_qty << 1);
            end
            mbrw_pkg::mbrw_t_hi: begin
              d.tx_data = reg_rdata_i[15:8];
              d.byte_lo = reg_rdata_i[7:0];
            end
            mbrw_pkg::mbrw_t_lo: begin
              d.tx_data = q.byte_lo;
            end
            mbrw_pkg::mbrw_t_crcl: begin
              d.tx_data = tx_crc.crc[7:0];
              d.byte_lo = tx_crc.crc[15:8];
            end
            mbrw_pkg::mbrw_t_crch: begin
              d.tx_data = q.byte_lo;
            end
            default: begin
              d.tx = mbrw_pkg::mbrw_t_addr;
              d.tx_valid = 1'b0;
            end
          endcase
        end else if (tx_take) begin
          d.tx_valid = 1'b0;
          unique case (q.tx)
            mbrw_pkg::mbrw_t_addr: d.tx = mbrw_pkg::mbrw_t_fc;
            mbrw_pkg::mbrw_t_fc: d.tx = mbrw_pkg::mbrw_t_cnt;
            mbrw_pkg::mbrw_t_cnt: begin
              d.tx = q.exc ? mbrw_pkg::mbrw_t_crcl : mbrw_pkg::mbrw_t_hi;
            end
            mbrw_pkg::mbrw_t_hi: d.tx = mbrw_pkg::mbrw_t_lo;
            mbrw_pkg::mbrw_t_lo: begin
              if (last_rd) begin
                d.tx = mbrw_pkg::mbrw_t_crcl;
              end else begin
                d.tx = mbrw_pkg::mbrw_t_hi;
                d.idx = q.idx + 8'h01;
                d.addr = q.addr + 16'h0001;
              end
            end
            mbrw_pkg::mbrw_t_crcl: d.tx = mbrw_pkg::mbrw_t_crch;
            mbrw_pkg::mbrw_t_crch: begin
              d.tx = mbrw_pkg::mbrw_t_addr;
              d.st = mbrw_pkg::mbrw_s_idle;
            end
            default: d.tx = mbrw_pkg::mbrw_t_addr;
          endcase
        end
      end
      default: begin
        d.st = mbrw_pkg::mbrw_s_idle;
        d.tx_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign tx_data_o = q.tx_data;
  assign tx_valid_o = q.tx_valid;
  assign reg_addr_o = q.addr;
  assign reg_wdata_o = q.wdata;
  assign reg_we_o = (q.st == mbrw_pkg::mbrw_s_write);
  assign other_func_o = q.other;
  assign busy_o = (q.st != mbrw_pkg::mbrw_s_idle);

endmodule

// [common/mbrw_consts.svh]
/*
  Constants of the read/write-multiple slave and its exception answers.
  Assumes one byte stream per frame and a 16-bit holding register map.
*/
// Function
// - Query fields: address, 17, read, write, data
// - Byte count gives write data bytes
// - Answer: address, code, count, read words
// - Frame address plus one gives register
// - Every unicast query gets an answer, except other known function codes (passed to other_func_o)
// - Errors answer address, code, exception, CRC
// - Exception function code is query plus 80h
// - Unsupported function code answers 01h
// - Missing register answers 02h
// - Bad counts or lengths answer 03h
// - Value out of range answers 21h
// - Write refused by state answers 22h
// - Write to read-only register answers 23h
// - Write first, then read back
// - Broadcast copies are never acted on
`ifndef MBRW_CONSTS_SVH
`define MBRW_CONSTS_SVH

`define MBRW_FC_RD_COILS 8'h01
`define MBRW_FC_RD_REGS 8'h03
`define MBRW_FC_WR_COIL 8'h05
`define MBRW_FC_WR_REG 8'h06
`define MBRW_FC_WR_COILS 8'h0f
`define MBRW_FC_WR_REGS 8'h10
`define MBRW_FC_RW_REGS 8'h17
`define MBRW_EXC_OFFSET 8'h80
`define MBRW_BROADCAST 8'h00

`define MBRW_EXC_FUNC 8'h01
`define MBRW_EXC_ADDR 8'h02
`define MBRW_EXC_FORMAT 8'h03
`define MBRW_EXC_RANGE 8'h21
`define MBRW_EXC_STATE 8'h22
`define MBRW_EXC_RDONLY 8'h23

`define MBRW_POS_ADDR 8'h00
`define MBRW_POS_FC 8'h01
`define MBRW_POS_RA 8'h02
`define MBRW_POS_RQ 8'h04
`define MBRW_POS_WA 8'h06
`define MBRW_POS_WQ 8'h08
`define MBRW_POS_BC 8'h0a
`define MBRW_POS_WDATA 8'h0b
`define MBRW_HDR_LEN 9'h00b
`define MBRW_CRC_LEN 9'h002
`define MBRW_MIN_FRAME 8'h04
`define MBRW_BUF_DEPTH 256

`define MBRW_MAX_RD_QTY 16'h007d
`define MBRW_MAX_WR_QTY 16'h0079
`define MBRW_REG_BASE 16'h0001

`define MBRW_CRC_INIT 16'hffff
`define MBRW_CRC_POLY 16'ha001

`endif

// [common/mbrw_pkg.sv]
/*
  Types of the read/write-multiple slave: states and state records.
  Assumes the constants header for field widths.
*/
package mbrw_pkg;

  typedef enum logic [2:0] {
    mbrw_s_idle = 3'h0,
    mbrw_s_chkw = 3'h1,
    mbrw_s_chkr = 3'h3,
    mbrw_s_write = 3'h2,
    mbrw_s_tx = 3'h6
  } mbrw_state_t;

  typedef enum logic [2:0] {
    mbrw_t_addr = 3'h0,
    mbrw_t_fc = 3'h1,
    mbrw_t_cnt = 3'h3,
    mbrw_t_hi = 3'h2,
    mbrw_t_lo = 3'h6,
    mbrw_t_crcl = 3'h7,
    mbrw_t_crch = 3'h5
  } mbrw_tx_t;

  typedef struct packed {
    mbrw_state_t st;
    mbrw_tx_t tx;
    logic [7:0] cnt;
    logic ovf;
    logic [7:0] idx;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic exc;
    logic [7:0] exc_code;
    logic [7:0] byte_lo;
    logic [7:0] tx_data;
    logic tx_valid;
    logic other;
  } mbrw_main_t;

  typedef struct packed {
    logic [15:0] crc;
  } mbrw_crc_state_t;

endpackage

// [common/mbrw_crc_if.sv]
/*
  Carrier between the frame handler and one CRC-16 engine.
  Assumes the engine updates one byte per clock.
*/
`timescale 1ns/10ps
interface mbrw_crc_if;
  logic clear;
  logic valid;
  logic [7:0] data;
  logic [15:0] crc;

  modport user (output clear, output valid, output data, input crc);
  modport engine (input clear, input valid, input data, output crc);
endinterface

// [logic/mbrw_crc.sv]
/*
  CRC-16 engine, reflected polynomial, one byte per clock.
  Assumes clear has priority over a byte in the same cycle.
*/
`timescale 1ns/10ps
`include "mbrw_consts.svh"
module mbrw_crc (
  input wire logic clk_i,
  input wire logic rst_i,
  mbrw_crc_if.engine crc_if
);

  mbrw_pkg::mbrw_crc_state_t s_q;
  mbrw_pkg::mbrw_crc_state_t s_d;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBRW_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    if (crc_if.clear) begin
      s_d.crc = `MBRW_CRC_INIT;
    end else if (crc_if.valid) begin
      s_d.crc = crc_byte(s_q.crc, crc_if.data);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{crc: `MBRW_CRC_INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign crc_if.crc = s_q.crc;

endmodule

// [verification/mbrw_slave_chk.sv]
/*
  Checker of the slave's byte handshake, write strobes and busy window.
  Assumes it is bound to the slave and sees only its ports.
*/
`timescale 1ns/10ps
module mbrw_slave_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_end_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic reg_we_o,
  input wire logic other_func_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  sequence s_wait;
    tx_valid_o && !tx_ready_i;
  endsequence
  sequence s_take;
    tx_valid_o && tx_ready_i;
  endsequence
  sequence s_start;
    rx_end_i && !busy_o ##1 busy_o;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_tx_hold:
    assert property (s_wait |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte dropped before taken");
  a_tx_gap:
    assert property (s_take |=> !tx_valid_o)
    else $error("no idle cycle after byte");
  a_tx_in_busy:
    assert property (tx_valid_o |-> busy_o)
    else $error("byte sent outside busy");
  a_we_in_busy:
    assert property (reg_we_o |-> busy_o && !tx_valid_o)
    else $error("write strobe while sending");
  a_other_silent:
    assert property (other_func_o |-> !busy_o && !tx_valid_o)
    else $error("answer for other function");
  a_busy_cause:
    assert property ($rose(busy_o) |-> $past(rx_end_i))
    else $error("busy without frame end");
  a_end_answers:
    assert property (s_start |-> ##[1:1000] tx_valid_o)
    else $error("accepted frame not answered");
  a_busy_release:
    assert property ($fell(busy_o) |-> $past(tx_valid_o)
                     || $past(tx_valid_o, 2))
    else $error("busy dropped without last byte");
endmodule

bind mbrw_slave mbrw_slave_chk chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .rx_end_i(rx_end_i),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .reg_we_o(reg_we_o),
  .other_func_o(other_func_o), .busy_o(busy_o)
);

// [verification/mbrw_master_model.sv]
/*
  Serial-line master model: sends query bytes, collects answer bytes.
  Assumes the bench calls send and reads got; inputs change at negedge.
*/
`timescale 1ns/10ps
module mbrw_master_model (
  input wire logic clk_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic slow = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [7:0] got [$];

  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
    tx_ready_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame check sequence, reflected, one bit per step
  function automatic logic [15:0] crc16(logic [7:0] f [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    end
    return c;
  endfunction

  // Bytes in order, CRC low first; bad CRC only on request
  task automatic send(logic [7:0] f [$], logic good);
    logic [15:0] c;
    c = crc16(f);
    if (!good)
      c = ~c;
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(negedge clk_i);
      rx_data_o = f[i];
      rx_valid_o = 1'b1;
      @(negedge clk_i);
      rx_valid_o = 1'b0;
      rx_data_o = ~rx_data_o;
    end
    @(negedge clk_i);
    rx_end_o = 1'b1;
    @(negedge clk_i);
    rx_end_o = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Stalls three cycles in four when slow
  always @(negedge clk_i) begin
    ph <= ph + 2'h1;
    tx_ready_o <= !slow || ph == 2'h3;
  end

  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
  end
endmodule

// [verification/mbrw_slave_tb.sv]
/*
  Self-checking bench of the read/write-multiple slave.
  Assumes the master model and a small register map kept here.
*/
`timescale 1ns/10ps
module mbrw_slave_tb;
  typedef logic [7:0] mbrw_q_t [$];
  localparam logic [7:0] SLV = 8'h08;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] slave_addr_i, rx_data_i, tx_data_o;
  logic rx_valid_i, rx_end_i, tx_valid_o, tx_ready_i, reg_we_o;
  logic [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic reg_exists_i, reg_read_only_i, reg_in_range_i, reg_run_locked_i;
  logic run_state_i, trip_state_i, undervoltage_state_i, soft_lock_i;
  logic other_func_o, busy_o;
  logic [15:0] mem [0:31];
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_we = 0;
  int n_other = 0;

  always #4 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  // Map: registers 1..16, 15 locked while running, 16 read-only
  assign reg_exists_i = reg_addr_o >= 16'h0001 && reg_addr_o <= 16'h0010;
  assign reg_read_only_i = reg_addr_o == 16'h0010;
  assign reg_run_locked_i = reg_addr_o == 16'h000f;
  assign reg_in_range_i = reg_wdata_o < 16'h8000;
  assign reg_rdata_i = mem[reg_addr_o[4:0]];

  always @(posedge clk_i) begin
    if (reg_we_o === 1'b1) begin
      mem[reg_addr_o[4:0]] <= reg_wdata_o;
      n_we <= n_we + 1;
    end
    if (other_func_o === 1'b1)
      n_other <= n_other + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      finish_test();
    end
  end

  mbrw_slave dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .slave_addr_i(slave_addr_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .rx_end_i(rx_end_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .reg_we_o(reg_we_o), .reg_rdata_i(reg_rdata_i),
    .reg_exists_i(reg_exists_i), .reg_read_only_i(reg_read_only_i),
    .reg_in_range_i(reg_in_range_i), .reg_run_locked_i(reg_run_locked_i),
    .run_state_i(run_state_i), .trip_state_i(trip_state_i),
    .undervoltage_state_i(undervoltage_state_i),
    .soft_lock_i(soft_lock_i), .other_func_o(other_func_o),
    .busy_o(busy_o));

  mbrw_master_model mst_u (.clk_i(clk_i), .rx_data_o(rx_data_i),
    .rx_valid_o(rx_valid_i), .rx_end_o(rx_end_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Reads registers 1 and 2, writes two words from frame address wa
  function automatic mbrw_q_t mk(logic [7:0] fc, logic [15:0] wa,
                                 logic [15:0] w1, logic [7:0] bc);
    return '{SLV, fc, 8'h00, 8'h00, 8'h00, 8'h02, wa[15:8], wa[7:0],
      8'h00, 8'h02, bc, 8'h00, 8'h00, w1[15:8], w1[7:0]};
  endfunction

  task automatic run(mbrw_q_t q, logic good);
    int n;
    n = 0;
    mst_u.got.delete();
    mst_u.send(q, good);
    repeat (2) @(negedge clk_i);
    while (busy_o === 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000)
      failures++;
  endtask

  task automatic expect_frame(mbrw_q_t e);
    logic [15:0] c;
    c = mst_u.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    chk(16'(mst_u.got.size()), 16'(e.size()));
    foreach (e[i]) chk({8'h00, mst_u.got[i]}, {8'h00, e[i]});
  endtask

  task automatic exc_case(logic [7:0] fc, logic [15:0] wa, logic [15:0] w1,
                          logic [7:0] bc, logic [7:0] code);
    run(mk(fc, wa, w1, bc), 1'b1);
    expect_frame('{SLV, 8'(fc + 8'h80), code});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_rw_normal();
    mst_u.slow = 1'b1;
    run(mk(8'h17, 16'h0000, 16'h1388, 8'h04), 1'b1);
    mst_u.slow = 1'b0;
    expect_frame('{SLV, 8'h17, 8'h04, 8'h00, 8'h00, 8'h13, 8'h88});
    chk(mem[2], 16'h1388);
    chk(mem[3], 16'hffff);
  endtask

  task automatic t_exc();
    int w;
    w = n_we;
    exc_case(8'h41, 16'h0000, 16'h0000, 8'h04, 8'h01);
    exc_case(8'h17, 16'h0040, 16'h0000, 8'h04, 8'h02);
    exc_case(8'h17, 16'h0000, 16'h0000, 8'h03, 8'h03);
    exc_case(8'h17, 16'h0000, 16'h8000, 8'h04, 8'h21);
    exc_case(8'h17, 16'h000e, 16'h0000, 8'h04, 8'h23);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      {run_state_i, trip_state_i, undervoltage_state_i, soft_lock_i} =
        4'h1 << i;
      exc_case(8'h17, 16'h000d, 16'h0000, 8'h04, 8'h22);
    end
    @(negedge clk_i);
    {run_state_i, trip_state_i, undervoltage_state_i, soft_lock_i} = 4'h0;
    chk(16'(n_we - w), 16'h0000);
  endtask

  task automatic t_silent();
    mbrw_q_t q;
    int w;
    w = n_we;
    q = mk(8'h17, 16'h0000, 16'h0001, 8'h04);
    run(q, 1'b0);
    chk(16'(mst_u.got.size()), 16'h0000);
    q[0] = 8'h09;
    run(q, 1'b1);
    chk(16'(mst_u.got.size()), 16'h0000);
    q[0] = 8'h00;
    run(q, 1'b1);
    chk(16'(mst_u.got.size()), 16'h0000);
    chk(16'(n_we - w), 16'h0000);
  endtask

  task automatic t_other();
    logic [7:0] codes [6] = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h0f, 8'h10};
    foreach (codes[i]) begin
      run(mk(codes[i], 16'h0000, 16'h0000, 8'h04), 1'b1);
      chk(16'(n_other), 16'(i + 1));
      chk(16'(mst_u.got.size()), 16'h0000);
    end
  endtask

  // Read range faults, read quantity limits and a runt frame
  task automatic t_fields();
    mbrw_q_t q;
    int w;
    w = n_we;
    q = mk(8'h17, 16'h0000, 16'h0000, 8'h04);
    q[3] = 8'h20;
    run(q, 1'b1);
    expect_frame('{SLV, 8'h97, 8'h02});
    q[3] = 8'h00;
    q[5] = 8'h7e;
    run(q, 1'b1);
    expect_frame('{SLV, 8'h97, 8'h03});
    q[5] = 8'h00;
    run(q, 1'b1);
    expect_frame('{SLV, 8'h97, 8'h03});
    chk(16'(n_we - w), 16'h0000);
    q = '{SLV};
    run(q, 1'b1);
    chk(16'(mst_u.got.size()), 16'h0000);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    slave_addr_i = SLV;
    {run_state_i, trip_state_i, undervoltage_state_i, soft_lock_i} = 4'h0;
    foreach (mem[i]) mem[i] = 16'hffff;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_rw_normal();
    t_exc();
    t_silent();
    t_other();
    t_fields();
    finish_test();
  end
endmodule
